// ===== design/isbc_core.sv
// boot mode, reprogramming control and security settings
// assumes core-side strobes on ref_clk; strap and idle pins are async
module isbc_core (
   input wire logic ref_clk,          // core clock
   input wire logic rst_n,            // sync reset, active low
   input wire logic clk_en,           // freezes all state when low
   input wire logic sfr_wr,           // register write strobe
   input wire logic sfr_rd,           // register read strobe
   input wire logic [7:0] sfr_addr,   // register address
   input wire logic [7:0] sfr_wdata,  // register write data
   input wire logic strap_p26,        // port 2.6 level pin
   input wire logic strap_p27,        // port 2.7 level pin
   input wire logic strap_p43,        // port 4.3 level pin
   input wire logic idle_in,          // core idle state pin
   input wire logic wake_in,          // interrupt wake pin
   input wire logic sec_prog,         // program security byte
   input wire logic [7:0] sec_wdata,  // bits to clear, low clears
   input wire logic chip_erase,       // whole chip erase pulse
   input wire logic [15:0] mem_addr,  // setting register address
   input wire logic id_rd,            // setting register read
   input wire logic tbl_ext_fetch,    // table read runs from external
   input wire logic [7:0] p0_raw,     // raw port 0 data
   output logic [7:0] sfr_rdata,      // register read data
   output logic soft_reboot,          // full reset request
   output logic aux_ram_on,           // auxiliary ram enable
   output logic loader_location_sel,  // loader location select
   output logic reprogram_enable,     // programming allowed
   output logic loader_boot_active,   // executing from loader bank
   output logic prog_mode,            // in programming mode
   output logic flash_writable,       // erase and program allowed
   output logic [7:0] id_rdata,       // setting register data
   output logic access_deny,          // memory access blocked
   output logic tbl_int_allow,        // table read may reach internal
   output logic [7:0] p0_out,         // port 0 data after scramble
   output logic osc_gain_halve        // amplifier half gain
);
   logic [2:0] s1_q, s2_q;
   logic [1:0] w1_q, w2_q;
   logic key_half_q, unlocked_q;
   logic [7:0] ctrl_q;
   logic [7:0] sec_q;
   logic forced_loader_boot_q;
   logic boot_done_q;
   logic [2:0] rb_cnt_q;
   isbc_pkg::isbc_mode_t mode_q;
   logic locked;
   logic ctrl_wr, key_wr;

   // two flops on every pin input, first stage read only by second;
   // no reset here so the chain holds real strap levels at release
   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         s1_q <= {strap_p43, strap_p27, strap_p26};
         s2_q <= s1_q;
         w1_q <= {wake_in, idle_in};
         w2_q <= w1_q;
      end
   end

   assign locked = !sec_q[isbc_pkg::SEC_LOCK];
   assign key_wr = sfr_wr && (sfr_addr == isbc_pkg::KEY_ADDR);
   assign ctrl_wr = sfr_wr && (sfr_addr == isbc_pkg::CTRL_ADDR) &&
                    unlocked_q;

   // unlock key sequence; a wrong value relocks at once
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         key_half_q <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (clk_en && key_wr) begin
         key_half_q <= (sfr_wdata == isbc_pkg::KEY_FIRST);
         unlocked_q <= key_half_q &&
                       (sfr_wdata == isbc_pkg::KEY_SECOND);
      end
   end

   // strap capture once after release, so a pin never feeds reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         forced_loader_boot_q <= 1'b0;
         boot_done_q <= 1'b0;
      end else if (clk_en && !boot_done_q) begin
         boot_done_q <= 1'b1;
         forced_loader_boot_q <= (!s2_q[1] && !s2_q[0]) || !s2_q[2];
      end
   end

   // control register; bits 3,2 forced zero, 6,5 reserved read zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= isbc_pkg::CTRL_RESET;
      end else if (clk_en && ctrl_wr) begin
         ctrl_q <= {1'b0, 2'b00, sfr_wdata[isbc_pkg::BIT_AUX], 2'b00,
                    sfr_wdata[isbc_pkg::BIT_LOC],
                    sfr_wdata[isbc_pkg::BIT_PROG]};
      end
   end

   // reboot pulse held a few cycles; the system reset reloads us
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rb_cnt_q <= 3'h0;
      end else if (clk_en) begin
         if (ctrl_wr && sfr_wdata[isbc_pkg::BIT_REBOOT] &&
             sfr_wdata[isbc_pkg::BIT_LOC] &&
             sfr_wdata[isbc_pkg::BIT_PROG]) begin
            rb_cnt_q <= 3'(isbc_pkg::REBOOT_CYCLES);
         end else if (rb_cnt_q != 3'h0) begin
            rb_cnt_q <= rb_cnt_q - 3'h1;
         end
      end
   end

   // programming mode entered only via idle then wake
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_q <= isbc_pkg::ISBC_RUN;
      end else if (clk_en) begin
         case (mode_q)
            isbc_pkg::ISBC_RUN:
               if (ctrl_q[isbc_pkg::BIT_PROG] && w2_q[0])
                  mode_q <= isbc_pkg::ISBC_IDLE_ARM;
            isbc_pkg::ISBC_IDLE_ARM:
               if (!ctrl_q[isbc_pkg::BIT_PROG])
                  mode_q <= isbc_pkg::ISBC_RUN;
               else if (w2_q[1])
                  mode_q <= isbc_pkg::ISBC_PROG;
            isbc_pkg::ISBC_PROG:
               if (!ctrl_q[isbc_pkg::BIT_PROG])
                  mode_q <= isbc_pkg::ISBC_RUN;
            default: mode_q <= isbc_pkg::ISBC_RUN;
         endcase
      end
   end

   // security byte: bits only fall, reset or whole erase restores them
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sec_q <= isbc_pkg::SEC_RESET;
      end else if (clk_en) begin
         if (chip_erase) begin
            sec_q <= isbc_pkg::SEC_RESET;
         end else if (sec_prog && mode_q != isbc_pkg::ISBC_PROG &&
                      !locked && mem_addr == isbc_pkg::SEC_ADDR) begin
            sec_q <= sec_q & sec_wdata;
         end
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
         soft_reboot <= 1'b0;
         aux_ram_on <= 1'b0;
         loader_location_sel <= 1'b0;
         reprogram_enable <= 1'b0;
         loader_boot_active <= 1'b0;
         prog_mode <= 1'b0;
         flash_writable <= 1'b0;
         id_rdata <= 8'h00;
         access_deny <= 1'b0;
         tbl_int_allow <= 1'b1;
         p0_out <= 8'h00;
         osc_gain_halve <= 1'b0;
      end else if (clk_en) begin
         if (sfr_rd && sfr_addr == isbc_pkg::CTRL_ADDR)
            sfr_rdata <= {forced_loader_boot_q, ctrl_q[6:0]};
         else
            sfr_rdata <= 8'h00;
         soft_reboot <= (rb_cnt_q != 3'h0);
         aux_ram_on <= ctrl_q[isbc_pkg::BIT_AUX];
         loader_location_sel <= ctrl_q[isbc_pkg::BIT_LOC];
         reprogram_enable <= ctrl_q[isbc_pkg::BIT_PROG];
         loader_boot_active <= forced_loader_boot_q;
         prog_mode <= (mode_q == isbc_pkg::ISBC_PROG);
         flash_writable <= (mode_q == isbc_pkg::ISBC_PROG) &&
                           w2_q[0];
         // company and device id are constants; addresses 2 and 3 read the security byte
         if (id_rd && !locked &&
             mode_q != isbc_pkg::ISBC_PROG) begin
            case (mem_addr[1:0])
               2'h0: id_rdata <= isbc_pkg::COMPANY_ID;
               2'h1: id_rdata <= isbc_pkg::DEVICE_ID;
               default: id_rdata <= sec_q;
            endcase
         end else begin
            id_rdata <= 8'h00;
         end
         access_deny <= locked;
         tbl_int_allow <= sec_q[isbc_pkg::SEC_TBL] ||
                          !tbl_ext_fetch;
         p0_out <= sec_q[isbc_pkg::SEC_ENC] ? p0_raw :
                   (p0_raw ^ isbc_pkg::ENC_KEY);
         osc_gain_halve <= !sec_q[isbc_pkg::SEC_OSC];
      end
   end
endmodule // isbc_core

// ===== include/isbc_pkg.sv
// constants for the boot and security control block
// assumes an 8-bit special function register port on the core clock
package isbc_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hbf;         // control register
   localparam logic [7:0] KEY_ADDR = 8'hc7 - 8'h0c; // unlock key register
   localparam logic [7:0] KEY_FIRST = 8'h87;
   localparam logic [7:0] KEY_SECOND = 8'h59;
   localparam logic [15:0] SEC_ADDR = 16'hffff;     // security byte address
   localparam int BIT_REBOOT = 7;
   localparam int BIT_AUX = 4;
   localparam int BIT_LOC = 1;
   localparam int BIT_PROG = 0;
   localparam int SEC_LOCK = 1;
   localparam int SEC_TBL = 2;
   localparam int SEC_ENC = 3;
   localparam int SEC_OSC = 7;
   localparam logic [7:0] SEC_RESET = 8'hff;        // erased security byte
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ENC_KEY = 8'h5a;          // arbitrary scramble key
   localparam logic [7:0] COMPANY_ID = 8'h11;       // arbitrary value
   localparam logic [7:0] DEVICE_ID = 8'h22;        // arbitrary value
   localparam int REBOOT_CYCLES = 4;                // reset pulse length
   typedef enum logic [1:0] {ISBC_RUN, ISBC_IDLE_ARM, ISBC_PROG} isbc_mode_t;
endpackage

// ===== tb/isbc_core_props.sv
// checker for the boot and security control block
// assumes it is bound onto the core and sees only its ports
module isbc_core_props (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset
   input wire logic sfr_wr, // write
   input wire logic sfr_rd, // read
   input wire logic [7:0] sfr_addr, // address
   input wire logic [7:0] sfr_wdata, // data
   input wire logic id_rd, // id read
   input wire logic tbl_ext_fetch, // table fetch
   input wire logic [7:0] sfr_rdata, // read data
   input wire logic soft_reboot, // reboot
   input wire logic aux_ram_on, // aux ram
   input wire logic loader_location_sel, // location
   input wire logic reprogram_enable, // enable
   input wire logic loader_boot_active, // boot flag
   input wire logic prog_mode, // prog mode
   input wire logic flash_writable, // writable
   input wire logic [7:0] id_rdata, // id data
   input wire logic access_deny, // locked
   input wire logic tbl_int_allow // table allow
);
   logic reboot_req;
   // reboot write at the port; pulse may lag it by one or two edges
   assign reboot_req = sfr_wr && sfr_addr == isbc_pkg::CTRL_ADDR &&
      sfr_wdata[7] && sfr_wdata[1:0] == 2'b11;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ctrl_read_a: assert property (
      $past(sfr_rd && sfr_addr == isbc_pkg::CTRL_ADDR) |-> {sfr_rdata[7],
      sfr_rdata[4], sfr_rdata[1:0]} == {loader_boot_active, aux_ram_on,
      loader_location_sel, reprogram_enable}) else $error("control read bad");
   reboot_len_a: assert property ($rose(soft_reboot) |->
      soft_reboot[*4] ##1 !soft_reboot) else $error("reboot pulse length");
   reboot_cause_a: assert property ($rose(soft_reboot) |->
      $past(reboot_req) || $past(reboot_req, 2)) else $error("stray reboot");
   read_only_a: assert property (
      !reprogram_enable && !$past(reprogram_enable) |->
      !prog_mode && !flash_writable) else $error("writable while disabled");
   writable_a: assert property (flash_writable |->
      prog_mode || $past(prog_mode)) else $error("writable outside prog");
   prog_entry_a: assert property ($rose(prog_mode) |->
      reprogram_enable && $past(reprogram_enable)) else $error("prog entry");
   tbl_region_a: assert property (!tbl_int_allow |->
      $past(tbl_ext_fetch)) else $error("internal table read blocked");
   id_prog_a: assert property ($past(id_rd && prog_mode) |->
      id_rdata == 8'h00) else $error("setting read in prog mode");
   id_lock_a: assert property ($past(id_rd && access_deny) |->
      id_rdata == 8'h00) else $error("setting read while locked");
endmodule // isbc_core_props
bind isbc_core isbc_core_props u_props (.*);

// ===== tb/isbc_core_tb.sv
// self-checking bench for the boot and security control block
// assumes the checker binds itself onto the core
module isbc_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst_n, clk_en, sfr_wr, sfr_rd, strap_p26, strap_p27;
   logic strap_p43, idle_in, wake_in, sec_prog, chip_erase, id_rd;
   logic tbl_ext_fetch, soft_reboot, aux_ram_on, loader_location_sel;
   logic reprogram_enable, loader_boot_active, prog_mode, flash_writable;
   logic access_deny, tbl_int_allow, osc_gain_halve;
   logic [7:0] sfr_addr, sfr_wdata, sec_wdata, p0_raw, sfr_rdata, id_rdata;
   logic [7:0] p0_out, v, w;
   logic [15:0] mem_addr;
   int fails, samples_checked, seed, i;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   fails++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
   isbc_core u_dut (.*);
   // free-running core clock
   initial begin
      ref_clk = 0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic tick(int n = 1);
      repeat (n) @(negedge ref_clk);
   endtask
   // one strobe cycle; read data is caught in the cycle after
   task automatic sfr(logic wr, logic [7:0] a, logic [7:0] d);
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a, d};
      tick();
      {sfr_wr, sfr_rd} = 2'b00;
      v = sfr_rdata;
      tick();
   endtask
   task automatic wctl(logic [7:0] d);
      sfr(1, isbc_pkg::KEY_ADDR, isbc_pkg::KEY_FIRST);
      sfr(1, isbc_pkg::KEY_ADDR, isbc_pkg::KEY_SECOND);
      sfr(1, isbc_pkg::CTRL_ADDR, d);
   endtask
   task automatic idr(logic [15:0] a);
      {mem_addr, id_rd} = {a, 1'b1};
      tick();
      id_rd = 0;
      v = id_rdata;
      tick();
   endtask
   task automatic sec(logic [15:0] a, logic [7:0] d);
      {mem_addr, sec_wdata, sec_prog} = {a, d, 1'b1};
      tick();
      sec_prog = 0;
      tick(3);
   endtask
   // port 0 image with or without the scramble key
   function automatic logic [7:0] p0_exp(logic [7:0] r, logic enc);
      return enc ? r ^ isbc_pkg::ENC_KEY : r;
   endfunction
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #(100 * 3000);
      fails++;
      print_verdict();
   end
   // main sequence
   initial begin
      {seed, clk_en, rst_n, strap_p26, strap_p27, strap_p43} = {32'h4964, 5'h17};
      {sfr_wr, sfr_rd, id_rd, sec_prog, chip_erase, idle_in, wake_in} = 0;
      {sfr_addr, sfr_wdata, sec_wdata, p0_raw, tbl_ext_fetch, mem_addr} = 0;
      tick(20);
      rst_n = 1;
      tick();
      `CHK("boot", 2'b01, {loader_boot_active, tbl_int_allow})
      sfr(1, isbc_pkg::CTRL_ADDR, 8'h13); // still locked, ignored
      sfr(0, isbc_pkg::CTRL_ADDR, 8'h00);
      `CHK("locked", 8'h00, v)
      wctl(8'h13);
      `CHK("ctl", 3'b111, {aux_ram_on, loader_location_sel, reprogram_enable})
      clk_en = 0; // frozen: unlocked write must not land
      sfr(1, isbc_pkg::CTRL_ADDR, 8'h00);
      clk_en = 1;
      tick();
      `CHK("freeze", 1'b1, aux_ram_on)
      sfr(1, isbc_pkg::KEY_ADDR, 8'h00); // wrong key relocks
      sfr(1, isbc_pkg::CTRL_ADDR, 8'h00);
      `CHK("relock", 1'b1, aux_ram_on)
      for (i = 0; i < 8; i++) begin
         w = 8'($random(seed)) & 8'h13;
         wctl(w);
         sfr(0, isbc_pkg::CTRL_ADDR, 8'h00);
         `CHK("ctl_rd", w, v)
         p0_raw = 8'($random(seed));
         tick();
         `CHK("p0", p0_exp(p0_raw, 0), p0_out)
      end
      wctl(8'h01);
      idle_in = 1;
      tick(5);
      wake_in = 1;
      for (i = 0; i < 20 && prog_mode !== 1'b1; i++) tick();
      `CHK("prog", 2'b11, {prog_mode, flash_writable})
      idr(16'h0000);
      `CHK("id_prog", 8'h00, v)
      {idle_in, wake_in} = 2'b00;
      wctl(8'h00);
      tick(3);
      `CHK("ro", 2'b00, {prog_mode, flash_writable})
      idr(16'h0000);
      `CHK("company", isbc_pkg::COMPANY_ID, v)
      idr(16'h0001);
      `CHK("device", isbc_pkg::DEVICE_ID, v)
      sec(16'hfffe, 8'h00); // wrong address, refused
      idr(isbc_pkg::SEC_ADDR);
      `CHK("sec_addr", isbc_pkg::SEC_RESET, v)
      sec(isbc_pkg::SEC_ADDR, 8'h73);
      sec(isbc_pkg::SEC_ADDR, 8'hff);
      idr(isbc_pkg::SEC_ADDR);
      `CHK("sticky", 8'h73, v)
      `CHK("osc", 1'b1, osc_gain_halve)
      p0_raw = 8'ha5;
      tbl_ext_fetch = 1;
      tick(2);
      `CHK("enc", p0_exp(8'ha5, 1), p0_out)
      `CHK("tbl_ext", 1'b0, tbl_int_allow)
      sec(isbc_pkg::SEC_ADDR, 8'hfd);
      idr(16'h0000);
      `CHK("lock", 9'h100, {access_deny, v})
      chip_erase = 1;
      tick();
      chip_erase = 0;
      tick(3);
      `CHK("erase", 10'h0a5, {osc_gain_halve, access_deny, p0_out})
      // second reset with the port-4 strap low forces loader boot
      rst_n = 0;
      strap_p43 = 0;
      tick(4);
      rst_n = 1;
      tick(2);
      `CHK("strap", 1'b1, loader_boot_active)
      sfr(0, isbc_pkg::CTRL_ADDR, 8'h00);
      `CHK("boot_rd", 8'h80, v)
      wctl(8'h03);
      sfr(1, isbc_pkg::CTRL_ADDR, 8'h83);
      for (i = 0; i < 8 && soft_reboot !== 1'b1; i++) tick();
      `CHK("reboot", 1'b1, soft_reboot)
      tick(8);
      print_verdict();
   end
endmodule // isbc_core_tb
